// ### verification/sci_regs_chk.sv
// Purpose: Port-level assertions for the system control unit register bank
// Assumes: One clock aclk, synchronous active-low aresetn
// Notes: Sees only the top ports; bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module sci_regs_chk
  import sci_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  input wire logic irq
);
  // ==========================================================
  // Handshakes
  logic ar_take;
  logic w_take;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Bus timing
  a_read_answer: assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response moved");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && w_take
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_unmapped_err: assert property (ar_take && s_axi_araddr == 10'h3E8
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("hole answered");

  // ==========================================================
  // Register contents and interrupt
  a_rev_fixed: assert property (ar_take && s_axi_araddr == REV_OFF[NREV-1]
    |=> s_axi_rdata == REV_VAL[NREV-1]) else $error("top version word wrong");
  a_wo_read_zero: assert property (ar_take && (s_axi_araddr == OFF_IRQ_ENABLE_SET
    || s_axi_araddr == OFF_IRQ_ENABLE_CLEAR) |=> s_axi_rdata == 32'h0)
    else $error("write-only word read nonzero");
  a_reserved_zero: assert property (ar_take && (s_axi_araddr == OFF_IRQ_ENABLE_STATE
    || s_axi_araddr == OFF_IRQ_PENDING) |=> (s_axi_rdata & ~IRQ_USED_MASK) == 32'h0)
    else $error("reserved interrupt bit set");
  a_irq_masked: assert property (ar_take && s_axi_araddr == OFF_IRQ_ENABLE_STATE
    ##1 s_axi_rdata == 32'h0 |-> !irq) else $error("irq with nothing enabled");
  // Irq only drops as the result of a bus write
  a_irq_clear_cause: assert property ($fell(irq) |-> $past(w_take, 2)
    || $past(w_take, 3)) else $error("irq dropped without a write");

  c_pending_read: cover property (ar_take && s_axi_araddr == OFF_IRQ_PENDING);
  c_irq_rise: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind sci_regs sci_regs_chk sci_regs_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

// ### verification/sci_regs_tb_top.sv
// Purpose: Self-checking bench for the system control unit register bank
// Assumes: 200 MHz aclk, reset held 20 cycles, full-word AXI4-Lite accesses
// Notes: Flags driven on the bus clock; the design syncs them anyway
`timescale 1ns/10ps
`default_nettype none
module sci_regs_tb_top
  import sci_pkg::*;
;
  // ==========================================================
  // Signals
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] awaddr = 10'h0;
  logic [ADDR_W-1:0] araddr = 10'h0;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] flags = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [DATA_W-1:0] rdata, rd;
  logic [NCTRL*32-1:0] ctrl_words;
  int mismatches = 0;
  int checks = 0;

  always #2.5 aclk = ~aclk;

  sci_regs sci_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .power_clock_flags_in(flags), .fll_measured_ratio_in(32'h00C0FFEE),
    .ctrl_words(ctrl_words), .irq(irq));

  // ==========================================================
  // Bus and compare tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Starts one edge later so no strobe is driven twice in a time step
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    resp = bresp;
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string what);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    rd = rdata;
    resp = rresp;
    check(what, rd, exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_map();
    rd_chk(OFF_IRQ_ENABLE_STATE, IRQ_RESET, "mask at reset");
    rd_chk(OFF_IRQ_PENDING, IRQ_RESET, "pending at reset");
    rd_chk(10'h020, 32'h00000004, "slow xtal ctrl reset");
    rd_chk(OFF_FLL_MEASURED_RATIO, 32'h00C0FFEE, "measured ratio");
    for (int k = 0; k < NREV; k++) begin
      wr(REV_OFF[k], 32'hFFFFFFFF);
      rd_chk(REV_OFF[k], REV_VAL[k], "version word");
    end
    rd_chk(10'h3E8, 32'h0, "hole data");
    check("hole read resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(10'h054, 32'h1);
    check("hole write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    $display("t_map done");
  endtask

  task automatic t_mask();
    wr(OFF_IRQ_ENABLE_SET, 32'hFFFFFFFF);
    rd_chk(OFF_IRQ_ENABLE_STATE, IRQ_USED_MASK, "mask all");
    wr(OFF_IRQ_ENABLE_CLEAR, 32'h00000100);
    rd_chk(OFF_IRQ_ENABLE_STATE, IRQ_USED_MASK & ~32'h100, "mask less one");
    wr(OFF_IRQ_ENABLE_SET, 32'h0);
    wr(OFF_IRQ_ENABLE_CLEAR, 32'h0);
    rd_chk(OFF_IRQ_ENABLE_STATE, IRQ_USED_MASK & ~32'h100, "mask after zeros");
    rd_chk(OFF_IRQ_ENABLE_SET, 32'h0, "set word read");
    rd_chk(OFF_IRQ_ENABLE_CLEAR, 32'h0, "clear word read");
    wr(OFF_IRQ_ENABLE_CLEAR, 32'hFFFFFFFF);
    rd_chk(OFF_IRQ_ENABLE_STATE, 32'h0, "mask none");
    $display("t_mask done");
  endtask

  task automatic t_events();
    logic [31:0] exp;
    for (int i = 0; i < 32; i++) begin
      if (FLAG_EVENT_MASK[i]) begin
        exp = 32'h1 << i;
        flags <= exp;
        repeat (8) @(posedge aclk);
        rd_chk(OFF_POWER_CLOCK_FLAGS, exp, "flag level");
        rd_chk(OFF_IRQ_PENDING, exp, "pending on rise");
        check("irq while masked", {31'h0, irq}, 32'h0);
        wr(OFF_IRQ_PENDING_CLEAR, exp);
        repeat (8) @(posedge aclk);
        rd_chk(OFF_IRQ_PENDING, 32'h0, "pending with flag held");
        flags <= 32'h0;
        @(posedge aclk);
      end
    end
    exp = 32'h1 << BIT_BROWNOUT_SEEN;
    wr(OFF_IRQ_ENABLE_SET, exp);
    flags <= exp;
    repeat (8) @(posedge aclk);
    check("irq when enabled", {31'h0, irq}, 32'h1);
    wr(OFF_IRQ_ENABLE_CLEAR, exp);
    check("irq after disable", {31'h0, irq}, 32'h0);
    wr(OFF_IRQ_ENABLE_SET, exp);
    repeat (20) @(posedge aclk);
    check("irq still pending", {31'h0, irq}, 32'h1);
    wr(OFF_IRQ_PENDING_CLEAR, exp);
    check("irq after clear", {31'h0, irq}, 32'h0);
    wr(OFF_IRQ_ENABLE_CLEAR, 32'hFFFFFFFF);
    flags <= 32'h0;
    $display("t_events done");
  endtask

  // Key covers one write only, so the second plain write must trip again
  task automatic t_protect();
    wr(10'h01C, 32'h12345678);
    check("locked write resp", {30'h0, resp}, {30'h0, RESP_OKAY});
    rd_chk(10'h01C, 32'h0, "locked write dropped");
    rd_chk(OFF_IRQ_PENDING, 32'h80000000, "violation pending");
    wr(OFF_IRQ_PENDING_CLEAR, 32'h80000000);
    wr(OFF_WRITE_PROTECT_KEY, 32'hAA00001C);
    wr(10'h01C, 32'h12345678);
    rd_chk(10'h01C, 32'h12345678, "unlocked write");
    check("control word out", ctrl_words[31:0], 32'h12345678);
    rd_chk(OFF_IRQ_PENDING, 32'h0, "no violation");
    wr(10'h01C, 32'h0);
    rd_chk(OFF_IRQ_PENDING, 32'h80000000, "key used once");
    wr(OFF_IRQ_PENDING_CLEAR, 32'h80000000);
    $display("t_protect done");
  endtask

  // ==========================================================
  // Run control
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_map();
    t_mask();
    t_events();
    t_protect();
    test_done();
  end

  // Whole run needs about 700 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire

// ### verilog/sci_flag_sync.sv
// Purpose: Two-flop synchroniser and rise detector per status flag
// Assumes: Flags arrive from analog units outside the bus clock
// Notes: Rise is a one-cycle pulse, in the same cycle the level goes high
`timescale 1ns/10ps
`default_nettype none
module sci_flag_sync #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Flags
  input wire logic [WIDTH-1:0] flag_async,
  output logic [WIDTH-1:0] flag_level,
  output logic [WIDTH-1:0] flag_rise
);

  // ==========================================================
  // Per-bit stages
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic meta_next;
      logic sync_reg;
      logic sync_next;
      logic level_reg;
      logic level_next;
      logic rise_reg;
      logic rise_next;
      always_comb begin
        meta_next = flag_async[i];
        sync_next = meta_reg;
        level_next = sync_reg;
        rise_next = sync_reg & ~level_reg;
      end
      // First stage feeds only the second; rise compares stage two and three
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          level_reg <= 1'b0;
          rise_reg <= 1'b0;
        end else begin
          meta_reg <= meta_next;
          sync_reg <= sync_next;
          level_reg <= level_next;
          rise_reg <= rise_next;
        end
      end
      assign flag_level[i] = level_reg;
      assign flag_rise[i] = rise_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// ### verilog/sci_pkg.sv
// Purpose: Shared constants for the system control unit register bank
// Assumes: 32-bit AXI4-Lite data, 10-bit byte address inside the unit
// Notes: Offsets are byte addresses; version contents are arbitrary
package sci_pkg;

  // ==========================================================
  // Bus widths and responses
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Interrupt and flag registers
  localparam logic [9:0] OFF_IRQ_ENABLE_SET = 10'h000;
  localparam logic [9:0] OFF_IRQ_ENABLE_CLEAR = 10'h004;
  localparam logic [9:0] OFF_IRQ_ENABLE_STATE = 10'h008;
  localparam logic [9:0] OFF_IRQ_PENDING = 10'h00C;
  localparam logic [9:0] OFF_IRQ_PENDING_CLEAR = 10'h010;
  localparam logic [9:0] OFF_POWER_CLOCK_FLAGS = 10'h014;
  localparam logic [9:0] OFF_WRITE_PROTECT_KEY = 10'h018;
  localparam logic [9:0] OFF_FLL_MULTIPLIER = 10'h028;
  localparam logic [9:0] OFF_FLL_STEP_SIZE = 10'h02C;
  localparam logic [9:0] OFF_FLL_SPREAD_SPECTRUM = 10'h030;
  localparam logic [9:0] OFF_FLL_MEASURED_RATIO = 10'h034;
  localparam logic [9:0] OFF_FLL_SYNC_REQUEST = 10'h038;
  localparam logic [31:0] IRQ_RESET = 32'h00000000;

  // ==========================================================
  // Interrupt bit positions, same in all five registers; bit 30 is a readable flag only, not an interrupt
  localparam int BIT_PROTECT_VIOLATION = 31;
  localparam int BIT_RETAINED_WRITE_READY = 16;
  localparam int BIT_FLL_REF_STOPPED = 15;
  localparam int BIT_FLL_SYNC_READY = 14;
  localparam int BIT_FLL_LOCK_LOST_ACCURATE = 13;
  localparam int BIT_FLL_LOCK_LOST_FINE = 12;
  localparam int BIT_FLL_LOCK_LOST_COARSE = 11;
  localparam int BIT_FLL_LOCKED_ACCURATE = 10;
  localparam int BIT_FLL_LOCKED_FINE = 9;
  localparam int BIT_FLL_LOCKED_COARSE = 8;
  localparam int BIT_BROWNOUT_SEEN = 7;
  localparam int BIT_SUPPLY_LOW_SEEN = 6;
  localparam int BIT_REGULATOR_GOOD = 5;
  localparam int BIT_MAIN_OSC_READY = 1;
  localparam int BIT_SLOW_XTAL_READY = 0;
  localparam int BIT_RETAINED_VALID = 30;
  localparam logic [31:0] IRQ_USED_MASK = 32'h8001FFE3;
  localparam logic [31:0] FLAG_EVENT_MASK = 32'h0001FFE3;
  localparam logic [31:0] FLAG_READ_MASK = 32'h4001FFE3;

  // ==========================================================
  // Write-protect key word: key in top byte, target offset low
  localparam logic [7:0] UNLOCK_KEY = 8'hAA;
  localparam int UNLOCK_KEY_LSB = 24;

  // ==========================================================
  // Protected read/write control words
  localparam int NCTRL = 20;
  localparam logic [9:0] CTRL_OFF [0:NCTRL-1] = '{
    10'h01C, 10'h020, 10'h024, 10'h03C, 10'h040, 10'h044, 10'h048,
    10'h04C, 10'h050, 10'h058, 10'h05C, 10'h060, 10'h064, 10'h068,
    10'h06C, 10'h070, 10'h074, 10'h078, 10'h07C, 10'h080};
  localparam logic [31:0] CTRL_RST [0:NCTRL-1] = '{
    32'h00000000, 32'h00000004, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};

  // ==========================================================
  // Sub-unit version words; values arbitrary
  localparam int NREV = 13;
  localparam logic [9:0] REV_OFF [0:NREV-1] = '{
    10'h3C8, 10'h3CC, 10'h3D0, 10'h3D4, 10'h3D8, 10'h3DC, 10'h3E0,
    10'h3E4, 10'h3EC, 10'h3F0, 10'h3F4, 10'h3F8, 10'h3FC};
  localparam logic [31:0] REV_VAL [0:NREV-1] = '{
    32'h00000101, 32'h00000102, 32'h00000103, 32'h00000104,
    32'h00000105, 32'h00000106, 32'h00000107, 32'h00000108,
    32'h00000109, 32'h0000010A, 32'h0000010B, 32'h0000010C,
    32'h0000010D};

  // ==========================================================
  // Bus state machines
  typedef enum logic [1:0] {
    SCI_WR_IDLE = 2'b01,
    SCI_WR_RESP = 2'b10
  } sci_wr_state_t;

  typedef enum logic [1:0] {
    SCI_RD_IDLE = 2'b01,
    SCI_RD_DATA = 2'b10
  } sci_rd_state_t;

endpackage

// ### verilog/sci_regs.sv
// Purpose: AXI4-Lite register bank and interrupt logic of the system control unit
// Assumes: One write and one read outstanding at most; aligned word access
// Notes: Flags from analog units are synchronised before edge detection
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sci_regs
  import sci_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Unit status and control
  input wire logic [31:0] power_clock_flags_in,
  input wire logic [31:0] fll_measured_ratio_in,
  output logic [NCTRL*32-1:0] ctrl_words,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Flag synchroniser
  logic [31:0] flag_level;
  logic [31:0] flag_rise;

  sci_flag_sync #(
    .WIDTH(32)
  ) sci_flag_sync_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .flag_async(power_clock_flags_in),
    .flag_level(flag_level),
    .flag_rise(flag_rise)
  );

  // ==========================================================
  // State
  sci_wr_state_t wr_state_reg, wr_state_next;
  sci_rd_state_t rd_state_reg, rd_state_next;
  logic aw_held_reg, aw_held_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic w_held_reg, w_held_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] mask_reg, mask_next;
  logic [31:0] pend_reg, pend_next;
  logic irq_reg, irq_next;
  logic unlock_reg, unlock_next;
  logic [ADDR_W-1:0] unlock_off_reg, unlock_off_next;
  logic [31:0] ctrl_reg [0:NCTRL-1];
  logic [31:0] ctrl_next [0:NCTRL-1];

  // ==========================================================
  // Write decode
  logic do_write;
  logic [9:0] wr_off;
  logic [31:0] wr_bits;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic [31:0] ack_bits;
  logic violation;
  logic wr_mapped;

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  always_comb begin
    do_write = (wr_state_reg == SCI_WR_IDLE) & aw_held_reg & w_held_reg;
    wr_off = {aw_addr_reg[9:2], 2'b00};
    wr_bits = w_data_reg & strb_mask(w_strb_reg);
    set_bits = 32'h00000000;
    clr_bits = 32'h00000000;
    ack_bits = 32'h00000000;
    violation = 1'b0;
    wr_mapped = 1'b1;
    unlock_next = unlock_reg;
    unlock_off_next = unlock_off_reg;
    for (int k = 0; k < NCTRL; k++) begin
      ctrl_next[k] = ctrl_reg[k];
    end
    if (do_write) begin
      // Unlock opens exactly one following write
      unlock_next = 1'b0;
      case (wr_off)
        OFF_IRQ_ENABLE_SET: set_bits = wr_bits & IRQ_USED_MASK;
        OFF_IRQ_ENABLE_CLEAR: clr_bits = wr_bits & IRQ_USED_MASK;
        OFF_IRQ_PENDING_CLEAR: ack_bits = wr_bits & IRQ_USED_MASK;
        OFF_WRITE_PROTECT_KEY: begin
          if (w_strb_reg == 4'hF &&
              w_data_reg[UNLOCK_KEY_LSB +: 8] == UNLOCK_KEY) begin
            unlock_next = 1'b1;
            unlock_off_next = {w_data_reg[9:2], 2'b00};
          end
        end
        OFF_IRQ_ENABLE_STATE, OFF_IRQ_PENDING, OFF_POWER_CLOCK_FLAGS,
        OFF_FLL_MULTIPLIER, OFF_FLL_STEP_SIZE, OFF_FLL_SPREAD_SPECTRUM,
        OFF_FLL_MEASURED_RATIO, OFF_FLL_SYNC_REQUEST: wr_mapped = 1'b1;
        default: begin
          wr_mapped = 1'b0;
          for (int k = 0; k < NCTRL; k++) begin
            if (wr_off == CTRL_OFF[k]) begin
              wr_mapped = 1'b1;
              if (unlock_reg && unlock_off_reg == wr_off) begin
                ctrl_next[k] = (ctrl_reg[k] & ~strb_mask(w_strb_reg)) | wr_bits;
              end else begin
                violation = 1'b1;
              end
            end
          end
          // Version words ignore writes
          for (int k = 0; k < NREV; k++) begin
            if (wr_off == REV_OFF[k]) begin
              wr_mapped = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Interrupt logic
  logic [31:0] events;

  always_comb begin
    events = flag_rise & FLAG_EVENT_MASK;
    events[BIT_PROTECT_VIOLATION] = violation;
    mask_next = (mask_reg | set_bits) & ~clr_bits;
    // New event wins over a clear in the same cycle
    pend_next = (pend_reg & ~ack_bits) | events;
    irq_next = |(pend_next & mask_next);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= IRQ_RESET;
      pend_reg <= IRQ_RESET;
      irq_reg <= 1'b0;
      unlock_reg <= 1'b0;
      unlock_off_reg <= 10'h000;
    end else begin
      mask_reg <= mask_next;
      pend_reg <= pend_next;
      irq_reg <= irq_next;
      unlock_reg <= unlock_next;
      unlock_off_reg <= unlock_off_next;
    end
  end

  // ==========================================================
  // Control words
  genvar g;
  generate
    for (g = 0; g < NCTRL; g++) begin : g_ctrl
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctrl_reg[g] <= CTRL_RST[g];
        end else begin
          ctrl_reg[g] <= ctrl_next[g];
        end
      end
      assign ctrl_words[g*32 +: 32] = ctrl_reg[g];
    end
  endgenerate

  // ==========================================================
  // Write channel handshake
  always_comb begin
    wr_state_next = wr_state_reg;
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    case (wr_state_reg)
      SCI_WR_IDLE: begin
        if (do_write) begin
          aw_held_next = 1'b0;
          w_held_next = 1'b0;
          bvalid_next = 1'b1;
          bresp_next = wr_mapped ? RESP_OKAY : RESP_SLVERR;
          wr_state_next = SCI_WR_RESP;
        end
      end
      SCI_WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_next = 1'b0;
          wr_state_next = SCI_WR_IDLE;
        end
      end
      default: begin
        bvalid_next = 1'b0;
        wr_state_next = SCI_WR_IDLE;
      end
    endcase
    // Ready only while the holding slot stays empty
    awready_next = ~aw_held_next;
    wready_next = ~w_held_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= SCI_WR_IDLE;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 10'h000;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // ==========================================================
  // Read channel
  logic [9:0] rd_off;
  logic [31:0] rd_word;
  logic rd_mapped;

  always_comb begin
    rd_off = {s_axi_araddr[9:2], 2'b00};
    rd_word = 32'h00000000;
    rd_mapped = 1'b1;
    case (rd_off)
      OFF_IRQ_ENABLE_STATE: rd_word = mask_reg;
      OFF_IRQ_PENDING: rd_word = pend_reg;
      OFF_POWER_CLOCK_FLAGS: rd_word = flag_level & FLAG_READ_MASK;
      OFF_FLL_MEASURED_RATIO: rd_word = fll_measured_ratio_in;
      // Write-only words hold no readable state
      OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR, OFF_IRQ_PENDING_CLEAR,
      OFF_WRITE_PROTECT_KEY, OFF_FLL_MULTIPLIER, OFF_FLL_STEP_SIZE,
      OFF_FLL_SPREAD_SPECTRUM, OFF_FLL_SYNC_REQUEST: rd_word = 32'h00000000;
      default: begin
        rd_mapped = 1'b0;
        for (int k = 0; k < NCTRL; k++) begin
          if (rd_off == CTRL_OFF[k]) begin
            rd_mapped = 1'b1;
            rd_word = ctrl_reg[k];
          end
        end
        for (int k = 0; k < NREV; k++) begin
          if (rd_off == REV_OFF[k]) begin
            rd_mapped = 1'b1;
            rd_word = REV_VAL[k];
          end
        end
      end
    endcase
  end

  always_comb begin
    rd_state_next = rd_state_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rd_state_reg)
      SCI_RD_IDLE: begin
        if (s_axi_arvalid && arready_reg) begin
          rvalid_next = 1'b1;
          rdata_next = rd_word;
          rresp_next = rd_mapped ? RESP_OKAY : RESP_SLVERR;
          rd_state_next = SCI_RD_DATA;
        end
      end
      SCI_RD_DATA: begin
        if (s_axi_rready) begin
          rvalid_next = 1'b0;
          rd_state_next = SCI_RD_IDLE;
        end
      end
      default: begin
        rvalid_next = 1'b0;
        rd_state_next = SCI_RD_IDLE;
      end
    endcase
    arready_next = (rd_state_next == SCI_RD_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= SCI_RD_IDLE;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign irq = irq_reg;

endmodule
`default_nettype wire
